// [verilog/gjk_cfg.svh]
// Reset values and constant levels for the gated J-K storage element
`ifndef GJK_CFG_SVH
`define GJK_CFG_SVH

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GJK_Q_RST 1'h0
`define GJK_QN_RST 1'h1
`define GJK_CLK_RST 1'h0

// ----------------------------------------------------------------------------
// Pin levels
// ----------------------------------------------------------------------------
`define GJK_ACT_LOW 1'h0
`define GJK_HIGH 1'h1
`define GJK_LOW 1'h0

`endif

// [verilog/gjk_pkg.sv]
// Types shared by the gated J-K storage element
`default_nettype none

package gjk_pkg;

  // --------------------------------------------------------------------------
  // Edge action decoded from the gated requests
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    GJK_HOLD,
    GJK_SET,
    GJK_RESET,
    GJK_TOGGLE
  } gjk_action_e;

endpackage : gjk_pkg

`default_nettype wire

// [verilog/gjk_top.sv]
// Gated J-K positive-edge storage element with direct preset and clear
`timescale 1ns/100ps
`default_nettype none
`include "gjk_cfg.svh"

module gjk_top
  import gjk_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Device clock pin, sampled on clk_in
  input wire logic jk_clk_in,
  // Gated set request inputs
  input wire logic set_gate_a_in,
  input wire logic set_gate_b_in,
  input wire logic set_gate_n_in,
  // Gated reset request inputs
  input wire logic reset_gate_a_in,
  input wire logic reset_gate_b_in,
  input wire logic reset_gate_n_in,
  // Direct controls, active low
  input wire logic preset_n_in,
  input wire logic async_reset_n_in,
  // Outputs
  output logic q_out,
  output logic q_n_out
);

  // --------------------------------------------------------------------------
  // Request gating and edge detection
  // --------------------------------------------------------------------------
  logic jk_clk_ff;
  logic q_ff;
  logic qn_ff;
  logic nxt_q;
  logic nxt_qn;
  logic set_req;
  logic reset_req;
  logic clk_rise;
  logic force_pre;
  logic force_clr;
  gjk_action_e action;

  assign set_req = set_gate_a_in & set_gate_b_in & ~set_gate_n_in;
  assign reset_req = reset_gate_a_in & reset_gate_b_in & ~reset_gate_n_in;

  // The pin is synchronous to clk_in, so one stage of history gives the edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      jk_clk_ff <= `GJK_CLK_RST;
    end else begin
      jk_clk_ff <= jk_clk_in;
    end
  end

  assign clk_rise = jk_clk_in & ~jk_clk_ff;

  assign force_pre = (jk_clk_in == `GJK_LOW) && (preset_n_in == `GJK_ACT_LOW);
  assign force_clr = (jk_clk_in == `GJK_LOW) && (async_reset_n_in == `GJK_ACT_LOW);

  always_comb begin
    case ({set_req, reset_req})
      2'h2: action = GJK_SET;
      2'h1: action = GJK_RESET;
      2'h3: action = GJK_TOGGLE;
      default: action = GJK_HOLD;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    nxt_qn = ~q_ff;
    // Forces need the clock low and a rise needs it high, so they never meet
    if (force_pre && force_clr) begin
      nxt_q = `GJK_HIGH;
      nxt_qn = `GJK_HIGH;
    end else if (force_pre) begin
      nxt_q = `GJK_HIGH;
      nxt_qn = `GJK_LOW;
    end else if (force_clr) begin
      nxt_q = `GJK_LOW;
      nxt_qn = `GJK_HIGH;
    end else if (clk_rise) begin
      case (action)
        GJK_SET: nxt_q = `GJK_HIGH;
        GJK_RESET: nxt_q = `GJK_LOW;
        GJK_TOGGLE: nxt_q = ~q_ff;
        default: nxt_q = q_ff;
      endcase
      nxt_qn = ~nxt_q;
    end
    // Without a force the inverted output tracks ~q, so the both-high state
    // left by preset and clear decays on the first idle cycle
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_ff <= `GJK_Q_RST;
      qn_ff <= `GJK_QN_RST;
    end else begin
      q_ff <= nxt_q;
      qn_ff <= nxt_qn;
    end
  end

  assign q_out = q_ff;
  assign q_n_out = qn_ff;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  logic ctrl_idle;
  logic both_forced;
  assign ctrl_idle = preset_n_in && async_reset_n_in;
  assign both_forced = !jk_clk_in && !preset_n_in && !async_reset_n_in;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_no_edge_stable: assert property (
    (jk_clk_in == jk_clk_ff || !jk_clk_in) && !force_pre && !force_clr |=> $stable(q_out))
    else $error("q changed without a clock edge or force");

  a_lockout_high: assert property (
    jk_clk_in && jk_clk_ff ##1 jk_clk_in |-> $stable(q_out))
    else $error("q changed while device clock stayed high");

  a_lock_qn: assert property (
    jk_clk_in && jk_clk_ff ##1 jk_clk_in |-> $stable(q_n_out))
    else $error("q_n changed while device clock stayed high");

  a_set_gate: assert property (
    clk_rise && ctrl_idle && set_gate_a_in && set_gate_b_in && !set_gate_n_in
    && !(reset_gate_a_in && reset_gate_b_in && !reset_gate_n_in) |=> q_out && !q_n_out)
    else $error("gated set did not set");

  a_reset_gate: assert property (
    clk_rise && ctrl_idle && reset_gate_a_in && reset_gate_b_in && !reset_gate_n_in
    && !(set_gate_a_in && set_gate_b_in && !set_gate_n_in) |=> !q_out && q_n_out)
    else $error("gated reset did not reset");

  a_out_complement: assert property (
    !$past(both_forced) |-> q_out != q_n_out)
    else $error("outputs not complementary");

  a_force_clk_high: assert property (
    jk_clk_in && jk_clk_ff && (!preset_n_in || !async_reset_n_in) |=> $stable(q_out))
    else $error("preset or clear acted while clock high");

  a_qn_clk_high: assert property (
    jk_clk_in && jk_clk_ff && (!preset_n_in || !async_reset_n_in) |=> $stable(q_n_out))
    else $error("preset or clear moved q_n while clock high");

  a_both_low: assert property (
    both_forced ##1 !both_forced |-> q_out && q_n_out ##1 q_out != q_n_out)
    else $error("both-low state wrong");

  a_toggle_edge: assert property (
    clk_rise && ctrl_idle && set_req && reset_req |=> q_out != $past(q_out))
    else $error("toggle failed");

  a_toggle_qn: assert property (
    clk_rise && ctrl_idle && set_req && reset_req |=> q_n_out == $past(q_out))
    else $error("toggle left q_n wrong");

  a_hold_edge: assert property (
    clk_rise && ctrl_idle && !set_req && !reset_req |=> $stable(q_out) && q_out != q_n_out)
    else $error("hold edge changed q");

  a_preset_only: assert property (
    !jk_clk_in && !preset_n_in && async_reset_n_in |=> q_out && !q_n_out)
    else $error("preset did not force one");

  a_clear_only: assert property (
    !jk_clk_in && preset_n_in && !async_reset_n_in |=> !q_out && q_n_out)
    else $error("clear did not force zero");

  a_preset_over_req: assert property (
    !jk_clk_in && !preset_n_in && async_reset_n_in && reset_req |=> q_out && !q_n_out)
    else $error("reset request beat preset");

  a_clear_over_req: assert property (
    !jk_clk_in && preset_n_in && !async_reset_n_in && set_req |=> !q_out && q_n_out)
    else $error("set request beat clear");

  // --------------------------------------------------------------------------
  // Coverage
  // --------------------------------------------------------------------------

  c_toggle: cover property (clk_rise && ctrl_idle && set_req && reset_req);
  c_both_low: cover property (both_forced ##1 ctrl_idle);
  c_preset_then_edge: cover property (force_pre ##[1:4] clk_rise && ctrl_idle);
  c_hold_edge: cover property (clk_rise && ctrl_idle && !set_req && !reset_req);
  c_clear_only: cover property (force_clr && !force_pre);

endmodule : gjk_top

`default_nettype wire

// [verification/gjk_drv.sv]
// Surrounding logic model: turns a wanted J/K request into gate levels
`timescale 1ns/100ps
`default_nettype none

module gjk_drv (
  // Wanted requests and random filler for idle gates
  input wire logic j_in,
  input wire logic k_in,
  input wire logic [2:0] fill_in,
  // Gate levels, bit order a, b, n
  output logic [2:0] set_g_out,
  output logic [2:0] rst_g_out
);
  function automatic logic [2:0] gate(input logic on, input logic [2:0] f);
    return on ? 3'h6 : ((f == 3'h6) ? 3'h0 : f);
  endfunction : gate

  assign set_g_out = gate(j_in, fill_in);
  assign rst_g_out = gate(k_in, ~fill_in);
endmodule : gjk_drv

`default_nettype wire

// [verification/gjk_top_tb.sv]
// Self-checking bench for the gated J-K storage element
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin miscompares++; \
  $display("BAD %s exp %b got %b", n, e, s); end end

module gjk_top_tb;
  logic clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic jk_clk = 1'h0, pre_n = 1'h1, clr_n = 1'h1, j = 1'h0, k = 1'h0, chk = 1'h0;
  logic q, qn, eq;
  logic [2:0] fill = 3'h0;
  logic [2:0] sg, rg;
  logic [1:0] expq[$];
  logic [1:0] exp_pair;
  int miscompares = 0, comparisons = 0, seed = 92, op;

  always #5 clk_in = ~clk_in;

  gjk_drv u_drv (.j_in(j), .k_in(k), .fill_in(fill), .set_g_out(sg), .rst_g_out(rg));

  gjk_top u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .jk_clk_in(jk_clk),
    .set_gate_a_in(sg[2]), .set_gate_b_in(sg[1]), .set_gate_n_in(sg[0]),
    .reset_gate_a_in(rg[2]), .reset_gate_b_in(rg[1]), .reset_gate_n_in(rg[0]),
    .preset_n_in(pre_n), .async_reset_n_in(clr_n), .q_out(q), .q_n_out(qn));

  task automatic step();
    @(negedge clk_in);
    chk = 1'h0;
  endtask : step

  task automatic want(input logic [1:0] e);
    chk = 1'h1;
    expq.push_back(e);
  endtask : want

  task automatic test_done();
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Values read here are those left by the previous edge, so they are settled
  // Take the note once: the macro names its expected value twice
  always @(posedge clk_in) if (chk === 1'h1) begin
    exp_pair = expq.pop_front();
    `CHK("q pair", exp_pair, {q, qn})
  end

  initial begin
    repeat (5000) @(posedge clk_in);
    miscompares++;
    test_done();
  end

  initial begin
    eq = 1'h0;
    repeat (9) step();
    want(2'h1);
    step();
    rst_n_in = 1'h1;
    repeat (200) begin
      step();
      op = $random(seed) & 7;
      fill = 3'($random(seed));
      if (op < 4) begin
        j = op[0];
        k = op[1];
        step();
        jk_clk = 1'h1;
        step();
        eq = (j & k) ? ~eq : (j ? 1'h1 : (k ? 1'h0 : eq));
        j = ~j;
        k = ~k;
        fill = 3'($random(seed));
        want({eq, ~eq});
        // Clock stays high a third cycle so the lockout is seen twice
        step();
        fill = 3'($random(seed));
        want({eq, ~eq});
        step();
        jk_clk = 1'h0;
        want({eq, ~eq});
      end else if (op < 7) begin
        pre_n = (op == 5);
        clr_n = (op == 4);
        j = fill[1];
        k = fill[2];
        step();
        pre_n = 1'h1;
        clr_n = 1'h1;
        eq = (op != 5);
        want({eq, op != 4});
        step();
        want({eq, ~eq});
      end else begin
        jk_clk = 1'h1;
        pre_n = 1'h0;
        clr_n = fill[0];
        step();
        want({eq, ~eq});
        step();
        want({eq, ~eq});
        pre_n = 1'h1;
        clr_n = 1'h1;
        jk_clk = 1'h0;
      end
      j = 1'h0;
      k = 1'h0;
    end
    step();
    test_done();
  end
endmodule : gjk_top_tb

`default_nettype wire
